// ===== gpio_seq_regs.sv
// Register bank and channel sequencer of an eight-channel sampling converter.
// Assumes the serial protocol engine drives reg_req synchronous to core_clk and
// that the converter pulses conv_done once per finished conversion.
`timescale 1ns/1ns
`default_nettype none

module gpio_seq_regs
   import gpio_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire reg_req_t reg_req,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   input wire logic conv_done,
   output logic [2:0] conv_channel,
   output logic conv_channel_valid,
   output logic scan_active
);
   // ======================================================================
   // Registers
   logic [7:0] pin_function_reg, pin_function_next;
   logic [7:0] pin_direction_cfg_reg, pin_direction_cfg_next;
   logic [7:0] output_drive_cfg_reg, output_drive_cfg_next;
   logic [7:0] output_level_reg, output_level_next;
   logic [7:0] input_level_reg, input_level_next;
   logic sequence_start_bit_reg, sequence_start_bit_next;
   logic [1:0] scan_mode_field_reg, scan_mode_field_next;
   logic [3:0] manual_channel_field_reg, manual_channel_field_next;
   logic [7:0] scan_enable_field_reg, scan_enable_field_next;
   logic [7:0] rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic [7:0] pin_out_reg, pin_out_next;
   logic [7:0] pin_oe_reg, pin_oe_next;
   logic [7:0] gpo_mask;

   always_comb begin
      pin_function_next = pin_function_reg;
      pin_direction_cfg_next = pin_direction_cfg_reg;
      output_drive_cfg_next = output_drive_cfg_reg;
      output_level_next = output_level_reg;
      sequence_start_bit_next = sequence_start_bit_reg;
      scan_mode_field_next = scan_mode_field_reg;
      manual_channel_field_next = manual_channel_field_reg;
      scan_enable_field_next = scan_enable_field_reg;
      if (reg_req.wr) begin
         case (reg_req.addr)
            ADDR_PIN_FUNCTION: pin_function_next = reg_req.wdata;
            ADDR_PIN_DIRECTION: pin_direction_cfg_next = reg_req.wdata;
            ADDR_OUTPUT_DRIVE: output_drive_cfg_next = reg_req.wdata;
            ADDR_OUTPUT_LEVEL: output_level_next = reg_req.wdata;
            ADDR_SCAN_CONTROL: begin
               sequence_start_bit_next = reg_req.wdata[START_BIT];
               scan_mode_field_next = reg_req.wdata[MODE_MSB:0];
            end
            ADDR_MANUAL_CHANNEL: manual_channel_field_next = reg_req.wdata[CHID_MSB:0];
            ADDR_SCAN_ENABLE: scan_enable_field_next = reg_req.wdata;
            default: ;
         endcase
      end
   end

   // Pins of analog channels or digital outputs read back low, so software
   // never mistakes an analog voltage for a logic level.
   assign gpo_mask = pin_function_reg & pin_direction_cfg_reg;
   assign input_level_next = pin_in & pin_function_reg & ~pin_direction_cfg_reg;

   // One generate loop builds the per-pin driver; open-drain only enables its
   // output while pulling low.
   for (genvar i = 0; i < CH_COUNT; i++) begin : g_pin
      always_comb begin
         pin_out_next[i] = output_level_reg[i] & output_drive_cfg_reg[i];
         pin_oe_next[i] = gpo_mask[i] & (output_drive_cfg_reg[i] | ~output_level_reg[i]);
      end
   end

   always_comb begin
      rd_valid_next = reg_req.rd;
      rd_data_next = RESET_BYTE;
      if (reg_req.rd) begin
         case (reg_req.addr)
            ADDR_PIN_FUNCTION: rd_data_next = pin_function_reg;
            ADDR_PIN_DIRECTION: rd_data_next = pin_direction_cfg_reg;
            ADDR_OUTPUT_DRIVE: rd_data_next = output_drive_cfg_reg;
            ADDR_OUTPUT_LEVEL: rd_data_next = output_level_reg;
            ADDR_INPUT_LEVEL: rd_data_next = input_level_reg;
            ADDR_SCAN_CONTROL: begin
               rd_data_next[START_BIT] = sequence_start_bit_reg;
               rd_data_next[MODE_MSB:0] = scan_mode_field_reg;
            end
            ADDR_MANUAL_CHANNEL: rd_data_next[CHID_MSB:0] = manual_channel_field_reg;
            ADDR_SCAN_ENABLE: rd_data_next = scan_enable_field_reg;
            default: rd_data_next = RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_function_reg <= RESET_BYTE;
         pin_direction_cfg_reg <= RESET_BYTE;
         output_drive_cfg_reg <= RESET_BYTE;
         output_level_reg <= RESET_BYTE;
         input_level_reg <= RESET_BYTE;
         sequence_start_bit_reg <= 1'b0;
         scan_mode_field_reg <= MODE_MANUAL;
         manual_channel_field_reg <= 4'h0;
         scan_enable_field_reg <= RESET_BYTE;
         rd_data_reg <= RESET_BYTE;
         rd_valid_reg <= 1'b0;
         pin_out_reg <= RESET_BYTE;
         pin_oe_reg <= RESET_BYTE;
      end else if (clk_en) begin
         pin_function_reg <= pin_function_next;
         pin_direction_cfg_reg <= pin_direction_cfg_next;
         output_drive_cfg_reg <= output_drive_cfg_next;
         output_level_reg <= output_level_next;
         input_level_reg <= input_level_next;
         sequence_start_bit_reg <= sequence_start_bit_next;
         scan_mode_field_reg <= scan_mode_field_next;
         manual_channel_field_reg <= manual_channel_field_next;
         scan_enable_field_reg <= scan_enable_field_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   // ======================================================================
   // Sequencer
   // Lowest set bit of mask at or above start; wraps to the lowest set bit.
   function automatic logic [2:0] pick_from(input logic [7:0] mask, input logic [3:0] start);
      logic [2:0] idx;
      logic [2:0] low;
      idx = 3'h0;
      low = 3'h0;
      for (int k = CH_COUNT - 1; k >= 0; k--) begin
         if (mask[k]) begin
            low = 3'(k);
            if (4'(k) >= start) begin
               idx = 3'(k);
            end
         end
      end
      if (!(|(mask & ~((8'h01 << start[2:0]) - 8'h01))) || start[3]) begin
         idx = low;
      end
      return idx;
   endfunction

   scan_state_t state_reg, state_next;
   logic [2:0] conv_channel_reg, conv_channel_next;
   logic conv_channel_valid_reg, conv_channel_valid_next;
   logic [7:0] scan_mask;
   logic auto_go;

   // Only analog channels take part in a scan, whatever the enable says.
   assign scan_mask = scan_enable_field_reg & ~pin_function_reg;
   assign auto_go = sequence_start_bit_reg && (scan_mode_field_reg == MODE_AUTO);

   always_comb begin
      state_next = state_reg;
      conv_channel_next = conv_channel_reg;
      conv_channel_valid_next = 1'b0;
      case (state_reg)
         SCAN_IDLE: begin
            if (scan_mode_field_reg == MODE_MANUAL) begin
               // Reserved codes leave the channel unchanged and invalid.
               conv_channel_valid_next = (manual_channel_field_reg <= CHID_LAST);
               if (conv_channel_valid_next) begin
                  conv_channel_next = manual_channel_field_reg[2:0];
               end
            end else if (auto_go && (|scan_mask)) begin
               state_next = SCAN_RUN;
               conv_channel_next = pick_from(scan_mask, 4'h0);
               conv_channel_valid_next = 1'b1;
            end
         end
         SCAN_RUN: begin
            if (!auto_go || !(|scan_mask)) begin
               state_next = SCAN_IDLE;
            end else begin
               conv_channel_valid_next = 1'b1;
               if (conv_done) begin
                  conv_channel_next = pick_from(scan_mask, {1'b0, conv_channel_reg} + 4'h1);
               end else if (!scan_mask[conv_channel_reg]) begin
                  // A channel dropped from the scan mid-run is left at once, not at the next done.
                  conv_channel_next = pick_from(scan_mask, {1'b0, conv_channel_reg});
               end
            end
         end
         default: state_next = SCAN_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SCAN_IDLE;
         conv_channel_reg <= 3'h0;
         conv_channel_valid_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         conv_channel_reg <= conv_channel_next;
         conv_channel_valid_reg <= conv_channel_valid_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;
   assign conv_channel = conv_channel_reg;
   assign conv_channel_valid = conv_channel_valid_reg;
   assign scan_active = (state_reg == SCAN_RUN);

   // ======================================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_input_pin_oe: assert property (clk_en && !gpo_mask[0] |=> !pin_oe[0])
      else $error("Input pin 0 is driven.");
   a_push_pull_drive: assert property (clk_en && gpo_mask[0] && output_drive_cfg_reg[0]
      |=> pin_oe[0] && (pin_out[0] == $past(output_level_reg[0])))
      else $error("Push-pull pin 0 not driving its level.");
   a_open_drain_high: assert property (clk_en && output_level_reg[0] && !output_drive_cfg_reg[0]
      |=> !pin_oe[0])
      else $error("Open-drain pin 0 drives while high.");
   a_input_readback: assert property (clk_en && reg_req.rd && reg_req.addr == ADDR_INPUT_LEVEL
      |=> rd_valid && rd_data == $past(input_level_reg))
      else $error("Input level read mismatch.");
   a_start_stops: assert property (clk_en && scan_active && !auto_go |=> !scan_active)
      else $error("Scan did not stop.");
   a_scan_first_ch: assert property (clk_en && !scan_active && auto_go && scan_mask[0]
      |=> scan_active && conv_channel == 3'h0)
      else $error("Scan did not begin at channel 0.");
   a_manual_mode_idle: assert property (clk_en && scan_mode_field_reg == MODE_MANUAL
      ##1 clk_en && scan_mode_field_reg == MODE_MANUAL |=> !scan_active)
      else $error("Scan running in manual mode.");
   a_manual_select: assert property (clk_en && !scan_active && scan_mode_field_reg == MODE_MANUAL
      && manual_channel_field_reg == CHID_LAST |=> conv_channel == 3'h7)
      else $error("Manual channel 7 not selected.");
   a_reserved_code: assert property (clk_en && !scan_active && scan_mode_field_reg == MODE_MANUAL
      && manual_channel_field_reg[3] |=> !conv_channel_valid)
      else $error("Reserved manual code gave a channel.");
   a_reserved_zero: assert property (rd_valid && $past(reg_req.addr) == ADDR_SCAN_CONTROL
      |-> rd_data[7:5] == 3'h0 && rd_data[3:2] == 2'h0)
      else $error("Reserved scan control bits not zero.");
   a_gpio_excluded: assert property (scan_active |-> !pin_function_reg[conv_channel]
      || $changed(pin_function_reg))
      else $error("GPIO channel in scan.");
   a_enable_honoured: assert property (scan_active && $stable(scan_enable_field_reg)
      |-> scan_enable_field_reg[conv_channel])
      else $error("Disabled channel scanned.");

   c_scan_run: cover property (scan_active ##1 conv_done ##1 scan_active);
   c_manual_conv: cover property (!scan_active && conv_channel_valid && conv_channel == 3'h7);
   c_gpio_out: cover property (pin_oe[0] && pin_out[0]);
   c_scan_wrap: cover property (scan_active && conv_done ##1 conv_channel == 3'h0);
endmodule
`default_nettype wire

// ===== gpio_seq_pkg.sv
// Constants, register map and carrier types of the GPIO and scan-sequencing register bank.
// Assumes a serial protocol engine that presents one register access per request.
package gpio_seq_pkg;
   localparam int unsigned CH_COUNT = 8;
   localparam logic [7:0] ADDR_PIN_FUNCTION = 8'h05;
   localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h07;
   localparam logic [7:0] ADDR_OUTPUT_DRIVE = 8'h09;
   localparam logic [7:0] ADDR_OUTPUT_LEVEL = 8'h0b;
   localparam logic [7:0] ADDR_INPUT_LEVEL = 8'h0d;
   localparam logic [7:0] ADDR_SCAN_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_MANUAL_CHANNEL = 8'h11;
   localparam logic [7:0] ADDR_SCAN_ENABLE = 8'h12;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int unsigned START_BIT = 4;
   localparam int unsigned MODE_MSB = 1;
   localparam int unsigned CHID_MSB = 3;
   localparam logic [1:0] MODE_MANUAL = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h1;
   localparam logic [3:0] CHID_LAST = 4'h7;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [0:0] {
      SCAN_IDLE = 1'b0,
      SCAN_RUN = 1'b1
   } scan_state_t;
endpackage

// ===== gpio_seq_host.sv
// Host-side model that issues register accesses to the register bank.
// Assumes a free-running core_clk and clk_en high, except where a test freezes the block.
`timescale 1ns/1ns
`default_nettype none
module gpio_seq_host
   import gpio_seq_pkg::*;
(
   input wire logic core_clk,
   output var reg_req_t reg_req,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   initial reg_req = '0;
   // =======================================================
   // Bus cycles
   // Idle address and data show the inverse of the last value, so no stale match.
   task automatic release_bus();
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~reg_req.addr, wdata: ~reg_req.wdata};
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      #1 release_bus();
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge core_clk);
      #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge core_clk);
      // The answer stands for one cycle only, so it is taken before the release.
      #1 d = rd_data;
      v = rd_valid;
      release_bus();
   endtask
endmodule
`default_nettype wire

// ===== gpio_and_sequencer_regs_tb.sv
// Self-checking bench of the register bank, driven through the host model.
// Assumes the design package and both modules are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
module gpio_and_sequencer_regs_tb;
   import gpio_seq_pkg::*;
   logic core_clk = 0, rst_n = 0, conv_done = 0, clk_en = 1;
   logic [7:0] pin_in = 8'h00, rd_data, pin_out, pin_oe;
   logic rd_valid, conv_channel_valid, scan_active;
   logic [2:0] conv_channel;
   reg_req_t reg_req;
   int mismatches = 0, cmp_count = 0;
   logic [7:0] d;
   logic v;
   logic [7:0] rows [8][3] = '{'{8'h07, 8'ha5, 8'ha5}, '{8'h09, 8'h3c, 8'h3c},
      '{8'h0b, 8'hff, 8'hff}, '{8'h10, 8'hff, 8'h13}, '{8'h11, 8'hff, 8'h0f},
      '{8'h0d, 8'hff, 8'h00}, '{8'h20, 8'hff, 8'h00}, '{8'h12, 8'h81, 8'h81}};
   gpio_seq_regs dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .conv_done(conv_done),
      .conv_channel(conv_channel), .conv_channel_valid(conv_channel_valid),
      .scan_active(scan_active));
   gpio_seq_host host (.core_clk(core_clk), .reg_req(reg_req), .rd_data(rd_data),
      .rd_valid(rd_valid));
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   // =======================================================
   // Checks and verdict
   task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic check_read(input logic [7:0] a, input logic [7:0] e);
      host.read_reg(a, d, v);
      check("rd_valid", 8'h01, {7'h00, v});
      check("rd_data", e, d);
   endtask
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic pulse_done();
      @(posedge core_clk);
      #1 conv_done = 1;
      @(posedge core_clk);
      #1 conv_done = 0;
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end
   // =======================================================
   // Stimulus
   initial begin
      repeat (3) @(posedge core_clk);
      #1 rst_n = 1;
      foreach (rows[i]) check_read(rows[i][0], 8'h00);
      foreach (rows[i]) begin
         host.write_reg(rows[i][0], rows[i][1]);
         check_read(rows[i][0], rows[i][2]);
      end
      // Pins: channels 0-3 GPIO, 0-1 outputs, 0 push-pull, both set high, so only 0 is driven.
      host.write_reg(ADDR_PIN_FUNCTION, 8'h0f);
      host.write_reg(ADDR_PIN_DIRECTION, 8'h03);
      host.write_reg(ADDR_OUTPUT_DRIVE, 8'h01);
      host.write_reg(ADDR_OUTPUT_LEVEL, 8'h03);
      pin_in = 8'ha6;
      settle();
      check("pin_oe", 8'h01, pin_oe);
      check("pin_out", 8'h01, pin_out);
      check_read(ADDR_INPUT_LEVEL, 8'h04);
      host.write_reg(ADDR_OUTPUT_LEVEL, 8'h00);
      settle();
      check("pin_oe", 8'h03, pin_oe);
      check("pin_out", 8'h00, pin_out);
      // Manual codes, every channel analog first.
      host.write_reg(ADDR_PIN_FUNCTION, 8'h00);
      host.write_reg(ADDR_SCAN_CONTROL, 8'h10);
      for (int c = 0; c < 9; c++) begin
         host.write_reg(ADDR_MANUAL_CHANNEL, 8'(c));
         settle();
         check("scan_active", 8'h00, {7'h00, scan_active});
         check("conv_channel_valid", {7'h00, c < 8}, {7'h00, conv_channel_valid});
         if (c < 8) check("conv_channel", 8'(c), {5'h00, conv_channel});
      end
      host.write_reg(ADDR_SCAN_CONTROL, 8'h02);
      settle();
      check("conv_channel_valid", 8'h00, {7'h00, conv_channel_valid});
      // Auto scan over channels 2, 3, 5 with channel 2 taken as GPIO.
      host.write_reg(ADDR_SCAN_ENABLE, 8'h2c);
      host.write_reg(ADDR_PIN_FUNCTION, 8'h04);
      host.write_reg(ADDR_SCAN_CONTROL, 8'h11);
      settle();
      check("scan_active", 8'h01, {7'h00, scan_active});
      check("conv_channel", 8'h03, {5'h00, conv_channel});
      pulse_done();
      check("conv_channel", 8'h05, {5'h00, conv_channel});
      pulse_done();
      check("conv_channel", 8'h03, {5'h00, conv_channel});
      host.write_reg(ADDR_SCAN_CONTROL, 8'h01);
      settle();
      check("scan_active", 8'h00, {7'h00, scan_active});
      // Second scan over channels 0, 3, 5 wraps, then loses channel 0 to GPIO mid-run.
      host.write_reg(ADDR_SCAN_ENABLE, 8'h29);
      host.write_reg(ADDR_SCAN_CONTROL, 8'h11);
      settle();
      check("conv_channel", 8'h00, {5'h00, conv_channel});
      pulse_done();
      check("conv_channel", 8'h03, {5'h00, conv_channel});
      pulse_done();
      check("conv_channel", 8'h05, {5'h00, conv_channel});
      pulse_done();
      check("conv_channel", 8'h00, {5'h00, conv_channel});
      host.write_reg(ADDR_PIN_FUNCTION, 8'h05);
      settle();
      check("conv_channel", 8'h03, {5'h00, conv_channel});
      // Reset lands in the middle of the running scan.
      @(posedge core_clk);
      #1 rst_n = 0;
      @(posedge core_clk);
      #1 rst_n = 1;
      check("scan_active", 8'h00, {7'h00, scan_active});
      check_read(ADDR_SCAN_ENABLE, 8'h00);
      // A write while the clock enable is low must leave no trace.
      clk_en = 0;
      host.write_reg(ADDR_OUTPUT_LEVEL, 8'hff);
      clk_en = 1;
      check_read(ADDR_OUTPUT_LEVEL, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
